/* verilog/rsie_cfg.svh */
/*
 * Constants of the interleaved, shortened Reed-Solomon encoder.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef RSIE_CFG_SVH
`define RSIE_CFG_SVH
`define RSIE_SYM_W     8
`define RSIE_N         255
`define RSIE_E_HI      16
`define RSIE_E_LO      8
`define RSIE_NPAR_MAX  32
`define RSIE_I_MAX     8
`define RSIE_POLY_LOW  8'h87
`define RSIE_ROOT_STEP 11
`define RSIE_ROOT_BASE 128
`define RSIE_CNT_W     12
`define RSIE_DEPTH_W   4
`endif

/* verilog/rsie_pkg.sv */
/*
 * Types and Galois-field helpers of the Reed-Solomon encoder.
 * Assumes the constants header is on the include path.
 */
`include "rsie_cfg.svh"
package rsie_pkg;
	typedef enum logic [1:0] {RSIE_IDLE, RSIE_DATA, RSIE_PARITY} rsie_state_e;
	typedef logic [`RSIE_NPAR_MAX:0][`RSIE_SYM_W-1:0] rsie_coef_t;

	function automatic logic [7:0] rsie_gf_mul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				p = p ^ x;
			end
			x = x[7] ? ({x[6:0], 1'b0} ^ `RSIE_POLY_LOW) : {x[6:0], 1'b0};
		end
		return p;
	endfunction

	function automatic logic [7:0] rsie_gf_pow(input int e);
		logic [7:0] r;
		r = 8'h01;
		for (int i = 0; i < (e % `RSIE_N); i++) begin
			r = rsie_gf_mul(r, 8'h02);
		end
		return r;
	endfunction

	// Coefficients of g(x), index i is the coefficient of x^i.
	function automatic rsie_coef_t rsie_gen(input int e);
		rsie_coef_t g;
		logic [7:0] root;
		g = '0;
		g[0] = 8'h01;
		for (int j = `RSIE_ROOT_BASE - e; j <= `RSIE_ROOT_BASE - 1 + e; j++) begin
			root = rsie_gf_pow(`RSIE_ROOT_STEP * j);
			for (int i = `RSIE_NPAR_MAX; i > 0; i--) begin
				g[i] = g[i-1] ^ rsie_gf_mul(g[i], root);
			end
			g[0] = rsie_gf_mul(g[0], root);
		end
		return g;
	endfunction
endpackage

/* verilog/rsie_lfsr.sv */
/*
 * One codeword's parity register: a systematic division by g(x).
 * Assumes the parent feeds symbols and shifts out parity one lane at a time.
 */
`timescale 1ns/1ps
`include "rsie_cfg.svh"
module rsie_lfsr
	import rsie_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       clr,
	input  wire logic       e16,
	input  wire logic       feed,
	input  wire logic       shift,
	input  wire logic [7:0] din,
	output logic      [7:0] top
);
	localparam rsie_coef_t G_HI = rsie_gen(`RSIE_E_HI);
	localparam rsie_coef_t G_LO = rsie_gen(`RSIE_E_LO);

	logic [7:0] par_r [`RSIE_NPAR_MAX];
	wire  [7:0] fb = din ^ top;

	// With eight-symbol correction only the low sixteen stages are in use.
	assign top = e16 ? par_r[`RSIE_NPAR_MAX-1] : par_r[2*`RSIE_E_LO-1];

	genvar i;
	generate
		for (i = 0; i < `RSIE_NPAR_MAX; i++) begin : g_stage
			wire [7:0] prev = (i == 0) ? 8'h00 : par_r[(i == 0) ? 0 : i-1];
			wire [7:0] tap  = e16 ? rsie_gf_mul(fb, G_HI[i]) : rsie_gf_mul(fb, G_LO[i]);
			always_ff @(posedge ref_clk) begin
				if (rst || clr) begin
					par_r[i] <= 8'h00;
				end else if (feed) begin
					par_r[i] <= prev ^ tap;
				end else if (shift) begin
					par_r[i] <= prev;
				end
			end
		end
	endgenerate
endmodule

/* verilog/rsie_encoder.sv */
/*
 * Interleaved, shortened Reed-Solomon codeblock encoder with 8-bit symbols.
 * Assumes the downstream stage takes one symbol on every cycle out_valid is high,
 * and ignores any start that arrives while busy is high.
 */
`timescale 1ns/1ps
`include "rsie_cfg.svh"
module rsie_encoder
	import rsie_pkg::*;
#(
	parameter int DEPTH_MAX = `RSIE_I_MAX
)
(
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	input  wire logic                     start,
	input  wire logic                     cfg_e16,
	input  wire logic [`RSIE_DEPTH_W-1:0] cfg_depth,
	input  wire logic [`RSIE_CNT_W-1:0]   cfg_fill,
	input  wire logic                     cfg_concat,
	input  wire logic                     in_valid,
	input  wire logic [7:0]               in_data,
	output logic                          in_ready,
	output logic                          out_valid,
	output logic      [7:0]               out_data,
	output logic                          out_sop,
	output logic                          out_eop,
	output logic                          busy,
	output logic                          cfg_err
);
	rsie_state_e                state_r;
	rsie_state_e                state_nxt;
	logic                       busy_r;
	logic                       e16_r;
	logic [`RSIE_DEPTH_W-1:0]   depth_r;
	logic [`RSIE_DEPTH_W-1:0]   sel_r;
	logic [`RSIE_CNT_W-1:0]     cnt_r;
	logic [`RSIE_CNT_W-1:0]     data_len_r;
	logic [`RSIE_CNT_W-1:0]     par_len_r;
	logic                       first_r;
	logic                       in_ready_r;
	logic                       out_valid_r;
	logic [7:0]                 out_data_r;
	logic                       out_sop_r;
	logic                       out_eop_r;
	logic                       cfg_err_r;
	logic [7:0]                 top_w [DEPTH_MAX];

	// Legality of the requested configuration. A refused start keeps the last good
	// configuration, so a bad request can never disturb lanes that are still idle.
	wire                        depth_hi_ok = (cfg_depth >= 4'h1 && cfg_depth <= 4'h5) ||
	                                          (cfg_depth == 4'h8);
	wire                        depth_lo_ok = (cfg_depth == 4'h8);
	wire                        depth_ok    = cfg_e16 ? depth_hi_ok : depth_lo_ok;
	wire                        concat_ok   = cfg_e16 || !cfg_concat;
	wire [7:0]                  k_sym       = cfg_e16 ? 8'(`RSIE_N - 2*`RSIE_E_HI) :
	                                                    8'(`RSIE_N - 2*`RSIE_E_LO);
	wire [7:0]                  p_sym       = cfg_e16 ? 8'(2*`RSIE_E_HI) : 8'(2*`RSIE_E_LO);
	// Both factors are widened first so the product cannot wrap at eight bits.
	wire [`RSIE_CNT_W-1:0]      ki_len      = `RSIE_CNT_W'(k_sym) * `RSIE_CNT_W'(cfg_depth);
	wire [`RSIE_CNT_W-1:0]      pi_len      = `RSIE_CNT_W'(p_sym) * `RSIE_CNT_W'(cfg_depth);
	wire [`RSIE_CNT_W-1:0]      data_len_nxt = ki_len - cfg_fill;
	wire [`RSIE_CNT_W-1:0]      fill_mod    = depth_ok ? (cfg_fill % `RSIE_CNT_W'(cfg_depth)) :
	                                                     `RSIE_CNT_W'(0);
	wire                        fill_ok     = (fill_mod == `RSIE_CNT_W'(0)) &&
	                                          (cfg_fill < ki_len);
	wire                        cfg_good    = depth_ok && concat_ok && fill_ok;
	wire                        take_cfg    = (state_r == RSIE_IDLE) && start;
	wire                        clr_w       = take_cfg && cfg_good;

	// Stream control.
	wire                        accept      = (state_r == RSIE_DATA) && in_valid && in_ready_r;
	wire                        emit_par    = (state_r == RSIE_PARITY);
	wire                        data_last   = accept && (cnt_r == data_len_r - `RSIE_CNT_W'(1));
	wire                        par_last    = emit_par && (cnt_r == par_len_r - `RSIE_CNT_W'(1));
	wire                        adv         = accept || emit_par;
	wire                        cnt_wrap    = data_last || par_last;
	wire                        lane_end    = (sel_r == depth_r - `RSIE_DEPTH_W'(1));
	wire [`RSIE_DEPTH_W-1:0]    sel_nxt     = lane_end ? `RSIE_DEPTH_W'(0) :
	                                          sel_r + `RSIE_DEPTH_W'(1);
	wire [7:0]                  par_sym     = top_w[sel_r[2:0]];

	// Ready drops on the edge that takes the last data symbol, so the source
	// cannot push a symbol into the parity phase.
	wire                        in_ready_nxt = clr_w || (in_ready_r && !data_last);
	wire [7:0]                  out_data_nxt = accept ? in_data : par_sym;
	wire                        out_sop_nxt  = accept && first_r;
	wire                        busy_nxt     = (state_nxt != RSIE_IDLE);

	// One select line per lane; only the addressed codeword moves on a cycle.
	wire [DEPTH_MAX-1:0]        lane_hit;

	// Fill lies ahead of the data and is a whole number of rounds, so the zero
	// symbols would leave every cleared register at zero; they are skipped.
	genvar l;
	generate
		for (l = 0; l < DEPTH_MAX; l++) begin : g_lane
			assign lane_hit[l] = (sel_r == `RSIE_DEPTH_W'(l));
			rsie_lfsr u_lfsr (
				.ref_clk (ref_clk),
				.rst     (rst),
				.clr     (clr_w),
				.e16     (e16_r),
				.feed    (accept && lane_hit[l]),
				.shift   (emit_par && lane_hit[l]),
				.din     (in_data),
				.top     (top_w[l])
			);
		end
	endgenerate

	// Next-state decode; a refused start leaves the encoder idle.
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			RSIE_IDLE: begin
				if (clr_w) begin
					state_nxt = RSIE_DATA;
				end
			end
			RSIE_DATA: begin
				if (data_last) begin
					state_nxt = RSIE_PARITY;
				end
			end
			RSIE_PARITY: begin
				if (par_last) begin
					state_nxt = RSIE_IDLE;
				end
			end
			default: begin
				state_nxt = RSIE_IDLE;
			end
		endcase
	end

	// Busy is a flop of its own so that the port does not hang off a decoder.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= RSIE_IDLE;
			busy_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			busy_r  <= busy_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			e16_r      <= 1'b1;
			depth_r    <= `RSIE_DEPTH_W'(1);
			data_len_r <= `RSIE_CNT_W'(0);
			par_len_r  <= `RSIE_CNT_W'(0);
			cfg_err_r  <= 1'b0;
		end else if (take_cfg) begin
			cfg_err_r <= !cfg_good;
			if (cfg_good) begin
				e16_r      <= cfg_e16;
				depth_r    <= cfg_depth;
				data_len_r <= data_len_nxt;
				par_len_r  <= pi_len;
			end
		end
	end

	// Lane and symbol counters restart on every accepted start, so whatever a
	// reset cut short cannot leak into the next block.
	always_ff @(posedge ref_clk) begin
		if (rst || clr_w) begin
			sel_r   <= `RSIE_DEPTH_W'(0);
			cnt_r   <= `RSIE_CNT_W'(0);
			first_r <= 1'b1;
		end else if (adv) begin
			sel_r   <= sel_nxt;
			cnt_r   <= cnt_wrap ? `RSIE_CNT_W'(0) : cnt_r + `RSIE_CNT_W'(1);
			first_r <= 1'b0;
		end
	end

	// The inner encoder runs at symbol rate and takes every valid symbol, which
	// is why no output back-pressure exists and outputs stay pure flops.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			in_ready_r  <= 1'b0;
			out_valid_r <= 1'b0;
			out_data_r  <= 8'h00;
			out_sop_r   <= 1'b0;
			out_eop_r   <= 1'b0;
		end else begin
			in_ready_r  <= in_ready_nxt;
			out_valid_r <= adv;
			out_data_r  <= out_data_nxt;
			out_sop_r   <= out_sop_nxt;
			out_eop_r   <= par_last;
		end
	end

	assign in_ready  = in_ready_r;
	assign out_valid = out_valid_r;
	assign out_data  = out_data_r;
	assign out_sop   = out_sop_r;
	assign out_eop   = out_eop_r;
	assign busy      = busy_r;
	assign cfg_err   = cfg_err_r;
endmodule

/* verification/rsie_properties.sv */
/* Port checker of the encoder.
 * Assumes it is bound onto every rsie_encoder instance. */
`timescale 1ns/1ps
`include "rsie_cfg.svh"
module rsie_properties
	import rsie_pkg::*;
#(parameter int DEPTH_MAX = 8)
(
	input wire logic                     ref_clk,
	input wire logic                     rst,
	input wire logic                     start,
	input wire logic                     cfg_e16,
	input wire logic [`RSIE_DEPTH_W-1:0] cfg_depth,
	input wire logic [`RSIE_CNT_W-1:0]   cfg_fill,
	input wire logic                     cfg_concat,
	input wire logic                     in_valid,
	input wire logic [7:0]               in_data,
	input wire logic                     in_ready,
	input wire logic                     out_valid,
	input wire logic [7:0]               out_data,
	input wire logic                     out_sop,
	input wire logic                     out_eop,
	input wire logic                     busy,
	input wire logic                     cfg_err
);
	wire [11:0] k_i   = {8'h00, cfg_depth} * (cfg_e16 ? 12'h0df : 12'h0ef);
	wire        d_ok  = cfg_e16 ? cfg_depth inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8}
		: cfg_depth == 4'h8 && !cfg_concat;
	// A zero depth is refused by d_ok first, so the modulo never decides alone.
	wire        legal = d_ok && cfg_fill % {8'h00, cfg_depth} == 12'h000 && cfg_fill < k_i;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_take; start && !busy; endsequence
	sequence s_burst; out_valid [*8]; endsequence
	property p_rst; disable iff (1'b0) rst |=> !busy && !out_valid && !in_ready && !cfg_err;
	endproperty
	property p_good; s_take ##0 legal |=> busy && in_ready && !cfg_err; endproperty
	property p_bad; s_take ##0 !legal |=> cfg_err && !busy && !in_ready; endproperty
	property p_pass; in_valid && in_ready |=> out_valid && out_data == $past(in_data); endproperty
	property p_ign; start && busy |=> $stable(cfg_err); endproperty
	property p_eop; out_eop |=> !out_valid; endproperty
	property p_par; $fell(in_ready) && busy |-> s_burst; endproperty
	property p_sop; out_sop |-> out_valid && $past(in_ready); endproperty
	property p_end; out_eop |-> out_valid && !busy; endproperty
	a_rst: assert property (p_rst) else $error("not idle after reset");
	a_good: assert property (p_good) else $error("legal start refused");
	a_bad: assert property (p_bad) else $error("illegal start taken");
	a_pass: assert property (p_pass) else $error("data not passed");
	a_ign: assert property (p_ign) else $error("start taken while busy");
	a_eop: assert property (p_eop) else $error("output after end");
	a_par: assert property (p_par) else $error("check run broken");
	a_sop: assert property (p_sop) else $error("stray start flag");
	a_end: assert property (p_end) else $error("end flag off its symbol");
endmodule
bind rsie_encoder rsie_properties #(.DEPTH_MAX(DEPTH_MAX)) u_props (
	.ref_clk(ref_clk), .rst(rst), .start(start), .cfg_e16(cfg_e16),
	.cfg_depth(cfg_depth), .cfg_fill(cfg_fill), .cfg_concat(cfg_concat),
	.in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
	.out_data(out_data), .out_sop(out_sop), .out_eop(out_eop), .busy(busy), .cfg_err(cfg_err)
);

/* verification/rsie_sink.sv */
/* Inner encoder model that takes every code symbol.
 * Assumes one symbol per out_valid cycle and no back-pressure. */
`timescale 1ns/1ps
module rsie_sink
	import rsie_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       vld,
	input wire logic [7:0] dat,
	input wire logic       sop,
	input wire logic       eop
);
	logic [9:0] q[$];
	// The inner code cannot stall, so a symbol not taken here is lost for good.
	always @(posedge ref_clk) begin
		if (vld) begin
			q.push_back({eop, sop, dat});
		end
	end
endmodule

/* verification/rs_interleaved_shortened_encoder_tb_top.sv */
/* Self-checking bench of the encoder with seeded random data.
 * Assumes the checker and the sink model are compiled before it. */
`timescale 1ns/1ps
module rs_interleaved_shortened_encoder_tb_top
	import rsie_pkg::*;
();
	logic        ref_clk = 1'b0, rst = 1'b1, start = 1'b0, e = 1'b1, c = 1'b0, iv = 1'b0;
	logic [3:0]  dep = 4'h1;
	logic [11:0] fil = 12'h000;
	logic [7:0]  idt = 8'h00;
	logic [31:0] rs = 32'h00016e02;
	wire         rdy, ov, sop, eop, bsy, err;
	wire [7:0]   od;
	int          num_errors = 0, compares = 0;
	int          dl[6] = '{1, 2, 3, 4, 5, 8};
	always #5 ref_clk = ~ref_clk;
	rsie_encoder uut (.ref_clk(ref_clk), .rst(rst), .start(start), .cfg_e16(e),
		.cfg_depth(dep), .cfg_fill(fil), .cfg_concat(c), .in_valid(iv), .in_data(idt),
		.in_ready(rdy), .out_valid(ov), .out_data(od), .out_sop(sop), .out_eop(eop),
		.busy(bsy), .cfg_err(err));
	rsie_sink snk (.ref_clk(ref_clk), .vld(ov), .dat(od), .sop(sop), .eop(eop));
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		p = 8'h00;
		for (int k = 0; k < 8; k++) begin
			p = b[k] ? p ^ a : p;
			a = {a[6:0], 1'b0} ^ (a[7] ? 8'h87 : 8'h00);
		end
		return p;
	endfunction
	task automatic finish_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic stop();
		num_errors++;
		$display("CHECK FAILED t=%0t wait limit", $time);
		finish_test();
	endtask
	task automatic run(input logic te, input int ti, input int tq, input logic tc, input logic ok);
		logic [7:0] g[33];
		logic [7:0] pr[8][32];
		logic [7:0] fb;
		logic [9:0] ex[$];
		int         np, nd, n, w, l;
		np = te ? 32 : 16;
		nd = (255 - np) * ti - tq;
		g = '{default: 8'h00};
		pr = '{default: 8'h00};
		g[0] = 8'h01;
		for (int j = 128 - np / 2; j < 128 + np / 2; j++) begin
			fb = 8'h01;
			repeat ((11 * j) % 255) fb = gm(fb, 8'h02);
			for (int k = np; k > 0; k--) begin
				g[k] = g[k - 1] ^ gm(g[k], fb);
			end
			g[0] = gm(g[0], fb);
		end
		snk.q.delete();
		{start, e, dep, fil, c} = {1'b1, te, 4'(ti), 12'(tq), tc};
		@(negedge ref_clk);
		start = 1'b0;
		chk(err, !ok);
		chk(bsy, ok);
		if (!ok) begin
			@(negedge ref_clk);
			chk(snk.q.size(), 0);
			return;
		end
		// The leading fill symbols enter the model as zeros, lane by lane.
		for (int q = 0; q < tq; q++) begin
			l = q % ti;
			fb = pr[l][np - 1];
			for (int k = np - 1; k > 0; k--) begin
				pr[l][k] = pr[l][k - 1] ^ gm(fb, g[k]);
			end
			pr[l][0] = gm(fb, g[0]);
		end
		n = 0;
		// A start in mid-block must be ignored; fill rounds cost no symbols here.
		for (w = 0; n < nd && w < 20000; w++) begin
			iv = xs() % 4 != 0;
			idt = 8'(xs());
			start = n == 2;
			if (iv && rdy) begin
				l = (tq + n) % ti;
				fb = idt ^ pr[l][np - 1];
				for (int k = np - 1; k > 0; k--) begin
					pr[l][k] = pr[l][k - 1] ^ gm(fb, g[k]);
				end
				pr[l][0] = gm(fb, g[0]);
				ex.push_back({1'b0, n == 0, idt});
				n++;
			end
			@(negedge ref_clk);
		end
		{iv, start} = 2'b00;
		if (w >= 20000) stop();
		for (int p = 0; p < np; p++) begin
			for (int m = 0; m < ti; m++) begin
				ex.push_back({p == np - 1 && m == ti - 1, 1'b0, pr[m][np - 1 - p]});
			end
		end
		for (w = 0; snk.q.size() < ex.size() && w < 2000; w++) begin
			@(negedge ref_clk);
		end
		if (w >= 2000) stop();
		repeat (4) @(negedge ref_clk);
		chk(snk.q.size(), ex.size());
		foreach (ex[m]) begin
			chk(snk.q[m], ex[m]);
		end
		chk(bsy, 1'b0);
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		run(1'b1, 1, 222, 1'b0, 1'b1);
		run(1'b1, 8, 0, 1'b1, 1'b1);
		run(1'b0, 8, 8 * (xs() % 239), 1'b0, 1'b1);
		foreach (dl[m]) begin
			run(1'b1, dl[m], dl[m] * (xs() % 223), 1'(xs()), 1'b1);
		end
		run(1'b1, 6, 0, 1'b0, 1'b0);
		run(1'b1, 0, 0, 1'b0, 1'b0);
		run(1'b0, 4, 0, 1'b0, 1'b0);
		run(1'b0, 8, 0, 1'b1, 1'b0);
		run(1'b1, 3, 4, 1'b0, 1'b0);
		run(1'b1, 2, 446, 1'b0, 1'b0);
		run(1'b1, 4, 0, 1'b0, 1'b1);
		finish_test();
	end
endmodule
